// file: cpu_ctl_defs.svh
// Constants for the interrupt control and wide add execution block
// Summary of operation
// - Suspend opcode 76 halts execution, idling until an interrupt or reset.
// - Opcode F3 clears both enable latches, masking interrupts at once.
// - While masked, the maskable request input is ignored until re-enabled.
// - Opcode FB sets both enable latches to one.
// - No maskable interrupt accepted during FB or the next instruction.
// - Prefix ED then 46 selects interrupt mode 0.
// - Mode 0 executes the peripheral's instruction; first byte read at acknowledge.
// - ED 56 selects mode 1; accepted interrupt restarts at 0038.
// - ED 5E selects vectored interrupt mode 2.
// - Mode 2 forms table address from page register and peripheral vector.
// - Opcode 00ss1001 adds selected pair into the pointer pair.
// - Plain add keeps S, Z, P/V; H from bit 11; N clear; C from 15.
// - ED 01ss1010 adds pair plus carry into the pointer pair.
// - Add-with-carry sets S, Z, H, overflow, C; clears N.
// - ED 01ss0010 subtracts pair and carry from the pointer pair.
// - Subtract-with-borrow sets S, Z, overflow, H borrow from 12, C borrow, N.
// - DD 00pp1001 adds selected pair into the first index register.
// - Index add keeps S, Z, P/V; H from bit 11; N clear; C from 15.
`ifndef CPU_CTL_DEFS_SVH
`define CPU_CTL_DEFS_SVH
`define OP_SUSPEND 8'h76
`define OP_IRQ_DIS 8'hf3
`define OP_IRQ_EN 8'hfb
`define PFX_EXT 8'hed
`define PFX_IDX 8'hdd
`define OP_MODE0 8'h46
`define OP_MODE1 8'h56
`define OP_MODE2 8'h5e
`define RESTART_ADDR 16'h0038
`define FLAG_C 0
`define FLAG_N 1
`define FLAG_PV 2
`define FLAG_H 4
`define FLAG_Z 6
`define FLAG_S 7
`endif

// file: cpu_ctl_pkg.sv
// Types for the interrupt control and wide add execution block
package cpu_ctl_pkg;
	typedef enum logic [2:0] {
		ST_RUN = 3'b001,
		ST_EXT = 3'b010,
		ST_IDX = 3'b100
	} dec_state_e;
	typedef enum logic [1:0] {
		IMODE_0 = 2'd0,
		IMODE_1 = 2'd1,
		IMODE_2 = 2'd2
	} irq_mode_e;
	typedef struct packed {
		logic [15:0] pair_b_c;
		logic [15:0] pair_d_e;
		logic [15:0] primary_pointer_pair;
		logic [15:0] first_index_register;
		logic [15:0] stack_pointer;
		logic [7:0] flags;
	} regs_s;
	typedef struct packed {
		logic take;
		irq_mode_e mode;
		logic [15:0] target;
		logic [7:0] mode0_opcode;
	} irq_resp_s;
endpackage

// file: cpu_int_control_and_wide_add.sv
// Execution of halt, interrupt control, interrupt modes and 16-bit adds
`timescale 1ns/1ps
`include "cpu_ctl_defs.svh"
module cpu_int_control_and_wide_add
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Instruction byte stream from program memory
	input wire logic i_op_valid,
	input wire logic [7:0] i_op_byte,
	// Register load from the rest of the core
	input wire logic i_regs_load,
	input wire cpu_ctl_pkg::regs_s i_regs_in,
	input wire logic [7:0] i_vector_page,
	// Interrupting peripheral
	input wire logic i_irq_request_n,
	input wire logic [7:0] i_irq_data,
	// Outputs
	output cpu_ctl_pkg::regs_s o_regs,
	output cpu_ctl_pkg::irq_mode_e o_mode,
	output logic o_int_enable_latch_primary,
	output logic o_int_enable_latch_shadow,
	output logic o_halted,
	output logic o_instr_done,
	output logic o_irq_ack,
	output cpu_ctl_pkg::irq_resp_s o_irq_resp
);
	import cpu_ctl_pkg::*;

	// ==========================================
	// Request input synchroniser
	logic [2:0] irq_sync;
	logic irq_level;
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			irq_sync <= 3'b000;
		else
			irq_sync <= {irq_sync[1:0], ~i_irq_request_n};
	end
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
			irq_level <= 1'b0;
		else if (irq_sync[2] == irq_sync[1])
			irq_level <= irq_sync[2];
	end

	// ==========================================
	// Decode
	dec_state_e state;
	dec_state_e next_state;
	regs_s regs;
	regs_s next_regs;
	irq_mode_e mode;
	logic int_enable_latch_primary;
	logic int_enable_latch_shadow;
	logic halted;
	logic ei_shadow;
	wire run_byte = i_op_valid && (state == ST_RUN);
	wire ext_byte = i_op_valid && (state == ST_EXT);
	wire idx_byte = i_op_valid && (state == ST_IDX);
	wire is_suspend = run_byte && i_op_byte == `OP_SUSPEND;
	wire is_dis = run_byte && i_op_byte == `OP_IRQ_DIS;
	wire is_en = run_byte && i_op_byte == `OP_IRQ_EN;
	wire is_add = run_byte && i_op_byte[7:6] == 2'b00 && i_op_byte[3:0] == 4'h9;
	wire is_adc = ext_byte && i_op_byte[7:6] == 2'b01 && i_op_byte[3:0] == 4'ha;
	wire is_sbc = ext_byte && i_op_byte[7:6] == 2'b01 && i_op_byte[3:0] == 4'h2;
	wire is_addx = idx_byte && i_op_byte[7:6] == 2'b00 && i_op_byte[3:0] == 4'h9;
	wire is_im0 = ext_byte && i_op_byte == `OP_MODE0;
	wire is_im1 = ext_byte && i_op_byte == `OP_MODE1;
	wire is_im2 = ext_byte && i_op_byte == `OP_MODE2;
	wire [1:0] sel = i_op_byte[5:4];
	wire [15:0] hl_sel = sel == 2'b00 ? regs.pair_b_c : sel == 2'b01 ? regs.pair_d_e
		: sel == 2'b10 ? regs.primary_pointer_pair : regs.stack_pointer;
	wire [15:0] ix_sel = sel == 2'b00 ? regs.pair_b_c : sel == 2'b01 ? regs.pair_d_e
		: sel == 2'b10 ? regs.first_index_register : regs.stack_pointer;
	wire cy = regs.flags[`FLAG_C];
	wire [15:0] acc = is_addx ? regs.first_index_register : regs.primary_pointer_pair;
	wire [15:0] opnd = is_addx ? ix_sel : hl_sel;
	wire [15:0] opnd_x = is_sbc ? ~opnd : opnd;
	wire cin = is_sbc ? ~cy : (is_adc ? cy : 1'b0);
	wire [12:0] low_sum = {1'b0, acc[11:0]} + {1'b0, opnd_x[11:0]} + {12'h000, cin};
	wire [16:0] full_sum = {1'b0, acc} + {1'b0, opnd_x} + {16'h0000, cin};
	wire [15:0] result = full_sum[15:0];
	wire ovf = (acc[15] == opnd_x[15]) && (result[15] != acc[15]);
	wire half = is_sbc ? ~low_sum[12] : low_sum[12];
	wire carry = is_sbc ? ~full_sum[16] : full_sum[16];
	wire instr_end = is_suspend || is_dis || is_en || is_add || is_addx || ext_byte
		|| (run_byte && !(i_op_byte == `PFX_EXT || i_op_byte == `PFX_IDX))
		|| (idx_byte && !is_addx);
	// Interrupt accepted only when enabled and no enable instruction is pending
	wire irq_take = irq_level && int_enable_latch_primary && !ei_shadow && !is_en && !is_dis
		&& state == ST_RUN && (halted || !i_op_valid);

	always_comb
	begin
		next_state = state;
		if (run_byte)
			next_state = i_op_byte == `PFX_EXT ? ST_EXT
				: i_op_byte == `PFX_IDX ? ST_IDX : ST_RUN;
		else if (ext_byte || idx_byte)
			next_state = ST_RUN;
	end

	always_comb
	begin
		next_regs = regs;
		if (i_regs_load)
			next_regs = i_regs_in;
		else if (is_add)
		begin
			next_regs.primary_pointer_pair = result;
			next_regs.flags[`FLAG_H] = half;
			next_regs.flags[`FLAG_N] = 1'b0;
			next_regs.flags[`FLAG_C] = carry;
		end
		else if (is_addx)
		begin
			next_regs.first_index_register = result;
			next_regs.flags[`FLAG_H] = half;
			next_regs.flags[`FLAG_N] = 1'b0;
			next_regs.flags[`FLAG_C] = carry;
		end
		else if (is_adc || is_sbc)
		begin
			next_regs.primary_pointer_pair = result;
			next_regs.flags[`FLAG_S] = result[15];
			next_regs.flags[`FLAG_Z] = result == 16'h0000;
			next_regs.flags[`FLAG_H] = half;
			next_regs.flags[`FLAG_PV] = ovf;
			next_regs.flags[`FLAG_N] = is_sbc;
			next_regs.flags[`FLAG_C] = carry;
		end
	end

	// ==========================================
	// State registers
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			state <= ST_RUN;
			regs <= '0;
		end
		else
		begin
			state <= next_state;
			regs <= next_regs;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			mode <= IMODE_0;
			int_enable_latch_primary <= 1'b0;
			int_enable_latch_shadow <= 1'b0;
			halted <= 1'b0;
			ei_shadow <= 1'b0;
		end
		else
		begin
			if (is_im0)
				mode <= IMODE_0;
			else if (is_im1)
				mode <= IMODE_1;
			else if (is_im2)
				mode <= IMODE_2;
			if (is_dis || irq_take)
			begin
				int_enable_latch_primary <= 1'b0;
				int_enable_latch_shadow <= 1'b0;
			end
			else if (is_en)
			begin
				int_enable_latch_primary <= 1'b1;
				int_enable_latch_shadow <= 1'b1;
			end
			if (is_en)
				ei_shadow <= 1'b1;
			else if (instr_end)
				ei_shadow <= 1'b0;
			if (irq_take)
				halted <= 1'b0;
			else if (is_suspend)
				halted <= 1'b1;
		end
	end

	// ==========================================
	// Interrupt response
	always_ff @(posedge i_clk)
	begin
		if (i_sys_rst)
		begin
			o_irq_resp <= '0;
			o_instr_done <= 1'b0;
		end
		else
		begin
			o_instr_done <= instr_end;
			o_irq_resp.take <= irq_take;
			if (irq_take)
			begin
				o_irq_resp.mode <= mode;
				o_irq_resp.mode0_opcode <= i_irq_data;
				o_irq_resp.target <= mode == IMODE_1 ? `RESTART_ADDR
					: {i_vector_page, i_irq_data};
			end
		end
	end

	assign o_irq_ack = irq_take;
	assign o_regs = regs;
	assign o_mode = mode;
	assign o_int_enable_latch_primary = int_enable_latch_primary;
	assign o_int_enable_latch_shadow = int_enable_latch_shadow;
	assign o_halted = halted;

	// ==========================================
	// Checks
	chk_dis_clears: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_dis |=> !int_enable_latch_primary && !int_enable_latch_shadow) else $error("disable left latches set");
	chk_en_sets: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_en |=> int_enable_latch_primary && int_enable_latch_shadow) else $error("enable did not set latches");
	chk_no_take_masked: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!int_enable_latch_primary |=> !o_irq_resp.take) else $error("interrupt taken while masked");
	chk_ei_window: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_en |=> !irq_take) else $error("interrupt taken right after enable");
	chk_halt_holds: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_suspend && !irq_take |=> halted) else $error("suspend did not halt");
	chk_mode1_target: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		irq_take && mode == IMODE_1 |=> o_irq_resp.target == `RESTART_ADDR)
		else $error("mode 1 target wrong");
	chk_mode2_target: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		irq_take && mode == IMODE_2 |=> o_irq_resp.target == {$past(i_vector_page),
		$past(i_irq_data)}) else $error("mode 2 target wrong");
	chk_add_keeps: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_add && !i_regs_load |=> regs.flags[`FLAG_Z] == $past(regs.flags[`FLAG_Z])
		&& !regs.flags[`FLAG_N]) else $error("plain add changed kept flags");
	chk_sbc_sets_n: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		is_sbc && !i_regs_load |=> regs.flags[`FLAG_N]) else $error("borrow sub left N clear");
	chk_mode_held: assert property (@(posedge i_clk) disable iff (i_sys_rst)
		!ext_byte |=> mode == $past(mode)) else $error("mode changed without opcode");
endmodule

// file: irq_source_model.sv
// Interrupting peripheral: request line and data bus
`timescale 1ns/1ps
module irq_source_model
(
	// Clock
	input wire logic i_clk,
	// Bench control and acknowledge
	input wire logic i_start,
	input wire logic i_cancel,
	input wire logic i_ack,
	input wire logic [7:0] i_vec,
	// Request and data
	output logic o_req_n,
	output logic [7:0] o_data = 8'h5a
);
	// ====
	// Request held until acknowledged or cancelled; data toggles when not driven
	logic pend = 1'b0;
	always_ff @(posedge i_clk)
	begin
		pend <= i_start | (pend & ~i_ack & ~i_cancel);
		o_data <= pend ? i_vec : ~o_data;
	end
	assign o_req_n = ~pend;
endmodule

// file: test_cpu_int_control_and_wide_add.sv
// Self-checking bench for interrupt control and wide adds
`timescale 1ns/1ps
module test_cpu_int_control_and_wide_add;
	import cpu_ctl_pkg::*;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic i_op_valid = 1'b0;
	logic [7:0] i_op_byte = 8'h00;
	logic i_regs_load = 1'b0;
	regs_s i_regs_in = '0;
	logic [7:0] i_vector_page = 8'h00;
	logic [7:0] vec = 8'h00;
	logic start = 1'b0;
	logic cancel = 1'b0;
	logic req_n, ack, lp, ls, halted, done;
	logic [7:0] idata;
	regs_s o_regs;
	irq_mode_e o_mode;
	irq_resp_s resp;
	logic [31:0] seed = 32'd94551;
	logic [31:0] rv;
	int err_count = 0;
	int n_tests = 0;
	always #10 i_clk = ~i_clk;
	cpu_int_control_and_wide_add dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
		.i_op_valid(i_op_valid), .i_op_byte(i_op_byte), .i_regs_load(i_regs_load),
		.i_regs_in(i_regs_in), .i_vector_page(i_vector_page), .i_irq_request_n(req_n),
		.i_irq_data(idata), .o_regs(o_regs), .o_mode(o_mode),
		.o_int_enable_latch_primary(lp), .o_int_enable_latch_shadow(ls),
		.o_halted(halted), .o_instr_done(done), .o_irq_ack(ack), .o_irq_resp(resp));
	irq_source_model peer (.i_clk(i_clk), .i_start(start), .i_cancel(cancel),
		.i_ack(ack), .i_vec(vec), .o_req_n(req_n), .o_data(idata));
	// ====
	// Helpers
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [23:0] model(input int k, input logic [1:0] ss, input regs_s r);
		logic [15:0] a, b;
		logic [16:0] t;
		logic [12:0] h;
		logic [7:0] f;
		logic c;
		a = k == 3 ? r.first_index_register : r.primary_pointer_pair;
		b = ss == 0 ? r.pair_b_c : ss == 1 ? r.pair_d_e : ss == 2 ? a : r.stack_pointer;
		c = (k == 1 || k == 2) & r.flags[0];
		t = k == 2 ? {1'b0, a} - b - c : {1'b0, a} + b + c;
		h = k == 2 ? {1'b0, a[11:0]} - b[11:0] - c : {1'b0, a[11:0]} + b[11:0] + c;
		f = r.flags & 8'hd7;
		f[0] = t[16];
		f[1] = k == 2;
		f[4] = h[12];
		if (k == 1 || k == 2)
		begin
			f[7] = t[15];
			f[6] = t[15:0] == 0;
			f[2] = ((a[15] ^ b[15]) == (k == 2)) && (t[15] != a[15]);
		end
		return {t[15:0], f};
	endfunction
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic op(input logic [7:0] b);
		@(negedge i_clk);
		i_op_valid = 1'b1;
		i_op_byte = b;
	endtask
	task automatic idle();
		@(negedge i_clk);
		i_op_valid = 1'b0;
	endtask
	task automatic arith(input int i);
		int k;
		logic [1:0] ss;
		logic [95:0] w;
		logic [23:0] e;
		regs_s r;
		k = i % 4;
		w = {rnd(), rnd(), rnd()};
		r = w[87:0];
		ss = i < 8 ? 2'd0 : w[95:94];
		if (i < 8)
		begin
			r.pair_b_c = 16'h0001;
			r.primary_pointer_pair = i < 4 ? 16'hffff : 16'h7fff;
			r.first_index_register = r.primary_pointer_pair;
		end
		@(negedge i_clk);
		i_regs_load = 1'b1;
		i_regs_in = r;
		@(negedge i_clk);
		i_regs_load = 1'b0;
		if (k == 1 || k == 2)
			op(8'hed);
		if (k == 3)
			op(8'hdd);
		op(k == 1 ? {2'b01, ss, 4'b1010} : k == 2 ? {2'b01, ss, 4'b0010} : {2'b00, ss, 4'b1001});
		idle();
		e = model(k, ss, r);
		chk("pair", e[23:8], k == 3 ? o_regs.first_index_register : o_regs.primary_pointer_pair);
		chk("flags", e[7:0], o_regs.flags & 8'hd7);
		chk("done", 1, done);
	endtask
	task automatic take(input int m, input logic exp);
		int w;
		start = 1'b1;
		@(negedge i_clk);
		start = 1'b0;
		for (w = 0; w < 30 && ack !== 1'b1; w++)
			@(negedge i_clk);
		chk("ack", exp, ack);
		@(negedge i_clk);
		cancel = 1'b1;
		if (exp)
		begin
			chk("take", 1, resp.take);
			chk("rmode", m, resp.mode);
			chk("resp", m == 0 ? {8'h00, vec} : m == 1 ? 16'h0038 : {i_vector_page, vec},
				m == 0 ? {8'h00, resp.mode0_opcode} : resp.target);
			chk("after", 0, {lp, ls, halted});
		end
		@(negedge i_clk);
		cancel = 1'b0;
	endtask
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// Watchdog
	initial
	begin
		repeat (5000) @(posedge i_clk);
		err_count++;
		tally_and_finish();
	end
	// ====
	// Scenarios
	initial
	begin
		repeat (20) @(negedge i_clk);
		i_sys_rst = 1'b0;
		chk("rst", 0, {o_mode, lp, ls, halted});
		op(8'hfb);
		op(8'hed);
		op(8'h56);
		idle();
		for (int i = 0; i < 40; i++)
			arith(i);
		chk("keep", 16'h0007, {o_mode, lp, ls});
		for (int m = 0; m < 3; m++)
		begin
			op(8'hed);
			op(m == 0 ? 8'h46 : m == 1 ? 8'h56 : 8'h5e);
			op(8'hfb);
			op(m == 2 ? 8'h76 : 8'h00);
			idle();
			chk("mode", m, o_mode);
			chk("halt", m == 2, halted);
			rv = rnd();
			{i_vector_page, vec} = rv[15:0];
			take(m, 1'b1);
		end
		op(8'hf3);
		op(8'h76);
		idle();
		chk("mask", 16'h0001, {lp, ls, halted});
		take(1, 1'b0);
		chk("held", 1, halted);
		i_sys_rst = 1'b1;
		@(negedge i_clk);
		i_sys_rst = 1'b0;
		@(negedge i_clk);
		chk("unhalt", 0, {o_mode, lp, ls, halted});
		tally_and_finish();
	end
endmodule
